// *** edge_timer_pkg.sv ***
// Package with register map, field positions, reset values and bus carrier types for the edge-locked reload timer.
// Contract
// - 8-bit up-counter, prescaled clock, one in, one out.
// - PWM, capture, compare share the single pin pair (no capture is implemented here).
// - All control registers are 8 bits wide.
// - Active input edge reloads counter from reload register.
// - Counter equals compare value: output pin goes low.
// - Counter reaches 255: output pin goes high again.
// - After 255 counter wraps to 0, keeps counting.
// - Edge to falling output equals compare minus reload.
// - Output low lasts 255 minus compare counter periods.
// - Counter increments once per prescaled CPU clock.
// - Prescale ratio 1..128, or times three when selected.
// - Input pin event wakes the MCU from wait/stop.
// - Mode value 11100011b starts edge-reload mode, output enabled.
// - Active input edge polarity selected in second status register.
package edge_timer_pkg;

    // Widths of the data path and of the bus.
    localparam int CNT_W   = 8;
    localparam int ADR_W   = 10;
    localparam int WB_W    = 32;
    localparam int PSEL_W  = 3;
    localparam int DIV_W   = 9;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_MODE    = 8'hd5;
    localparam logic [7:0] IDX_STAT1   = 8'hd6;
    localparam logic [7:0] IDX_STAT2   = 8'hd7;
    localparam logic [7:0] IDX_COUNT   = 8'hd8;
    localparam logic [7:0] IDX_RELOAD  = 8'hd9;
    localparam logic [7:0] IDX_COMPARE = 8'hda;
    localparam logic [7:0] IDX_LOAD    = 8'hdb;

    // Field positions in mode_control.
    localparam int MC_OUT_EN_BIT = 7;
    localparam int MC_RUN_BIT    = 6;
    localparam int MC_EDGE_BIT   = 5;

    // Field positions in status_control_first.
    localparam int SC0_PS_LSB    = 0;
    localparam int SC0_FLAG_LSB  = 5;
    localparam int SC0_EDGE_FLAG = 5;
    localparam int SC0_CMP_FLAG  = 6;
    localparam int SC0_OVF_FLAG  = 7;

    // Field positions in status_control_second.
    localparam int SC1_TRIPLE_BIT = 0;
    localparam int SC1_PULLUP_BIT = 1;
    localparam int SC1_RISING_BIT = 2;

    // Reset values and fixed counter points.
    localparam logic [7:0] MODE_RST    = 8'h00;
    localparam logic [7:0] REG_RST     = 8'h00;
    localparam logic [2:0] FLAGS_RST   = 3'h0;
    localparam logic [2:0] PSEL_RST    = 3'h0;
    localparam logic       OUT_RST     = 1'b1;
    localparam logic [7:0] COUNT_TOP   = 8'hff;
    localparam logic [7:0] COUNT_ZERO  = 8'h00;
    localparam logic [7:0] MODE_START  = 8'he3;
    localparam logic [8:0] RATIO_ONE   = 9'h001;
    localparam logic [8:0] RATIO_THREE = 9'h003;

    // One Wishbone request as seen by the slave.
    typedef struct packed {
        logic              cyc;
        logic              stb;
        logic              we;
        logic [ADR_W-1:0]  adr;
        logic [3:0]        sel;
        logic [WB_W-1:0]   dat;
    } wb_req_t;

endpackage

// *** pin_edge_sync.sv ***
// Synchroniser and active-edge detector for the timer input pin.
`timescale 1ns/10ps
module pin_edge_sync (
    input  wire logic i_clk,
    input  wire logic i_resetn,
    input  wire logic i_pin,
    input  wire logic i_rising,
    output logic      o_level,
    output logic      o_edge
);
    logic s1_r, s2_r, s3_r;
    logic s1_nxt, s2_nxt, s3_nxt;

    // Shift the pin through two stages, plus one for the edge history.
    always_comb begin
        s1_nxt = i_pin;
        s2_nxt = s1_r;
        s3_nxt = s2_r;
    end

    // Registers of the chain.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
        end
    end

    // Only the second and third stages feed the polarity-selected edge.
    assign o_level = s2_r;
    assign o_edge  = i_rising ? (s2_r & ~s3_r) : (~s2_r & s3_r);
endmodule

// *** presc_div.sv ***
// Prescaler that turns the CPU clock into the counter increment strobe.
`timescale 1ns/10ps
module presc_div #(
    parameter int DIV_W = 9
) (
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_run,
    input  wire logic       i_triple,
    input  wire logic [2:0] i_sel,
    output logic            o_tick
);
    logic [DIV_W-1:0] div_r, div_nxt;
    logic [DIV_W-1:0] ratio;

    // The largest ratio, 384, needs nine bits.
    if (DIV_W < 9) begin : g_width_check
        $error("presc_div: DIV_W must be at least 9");
    end

    // Ratio is a power of two, or three times a power of two.
    always_comb begin
        ratio = DIV_W'((i_triple ? 9'h003 : 9'h001) << i_sel);
    end

    // Count CPU clocks and strobe once per ratio while running.
    assign o_tick = i_run && (div_r == ratio - DIV_W'(1));

    // Divider next value: cleared when stopped or on the strobe.
    always_comb begin
        if (!i_run || o_tick) begin
            div_nxt = '0;
        end else begin
            div_nxt = div_r + DIV_W'(1);
        end
    end

    // Divider register.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            div_r <= '0;
        end else begin
            div_r <= div_nxt;
        end
    end
endmodule

// *** edge_locked_reload_timer.sv ***
// Top of the edge-locked reload timer with its Wishbone register slave.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/10ps
module edge_locked_reload_timer (
    input  wire logic                                I_CLK,
    input  wire logic                                I_RESETN,
    input  wire logic                                I_WB_CYC,
    input  wire logic                                I_WB_STB,
    input  wire logic                                I_WB_WE,
    input  wire logic [edge_timer_pkg::ADR_W-1:0]    I_WB_ADR,
    input  wire logic [3:0]                          I_WB_SEL,
    input  wire logic [edge_timer_pkg::WB_W-1:0]     I_WB_DAT,
    output logic      [edge_timer_pkg::WB_W-1:0]     O_WB_DAT,
    output logic                                     O_WB_ACK,
    input  wire logic                                I_TIMER_IN,
    output logic                                     O_TIMER_OUT,
    output logic                                     O_TIMER_OUT_OE,
    output logic                                     O_PULLUP_EN,
    output logic                                     O_WAKE
);
    import edge_timer_pkg::*;

    wb_req_t           req;
    logic              hit, wr, ld_wr, changed;
    logic [7:0]        idx, wdat;
    logic              tick, edge_evt, run, edge_mode, reload_evt;
    logic [7:0]        mode_r, mode_nxt;
    logic [2:0]        psel_r, psel_nxt;
    logic [2:0]        flags_r, flags_nxt, flags_set;
    logic [7:0]        sc1_r, sc1_nxt;
    logic [7:0]        reload_r, reload_nxt;
    logic [7:0]        compare_r, compare_nxt;
    logic [7:0]        count_r, count_nxt;
    logic              out_r, out_nxt;
    logic              ack_r, ack_nxt;
    logic              wake_r, wake_nxt;
    logic [WB_W-1:0]   rdat_r, rdat_nxt;
    logic [7:0]        rd8;

    // Gather the bus signals into one request.
    assign req = '{cyc: I_WB_CYC, stb: I_WB_STB, we: I_WB_WE, adr: I_WB_ADR, sel: I_WB_SEL, dat: I_WB_DAT};

    // Decode: one access per request, taken on the edge that raises ack.
    assign hit   = req.cyc && req.stb && !ack_r;
    assign wr    = hit && req.we && req.sel[0];
    assign idx   = req.adr[ADR_W-1:2];
    assign wdat  = req.dat[7:0];
    assign ld_wr = wr && (idx == IDX_LOAD);

    assign run        = mode_r[MC_RUN_BIT];
    assign edge_mode  = mode_r[MC_EDGE_BIT];
    assign reload_evt = run && edge_mode && edge_evt;

    // Input pin synchroniser with selectable active edge.
    pin_edge_sync u_sync (
        .i_clk    (I_CLK),
        .i_resetn (I_RESETN),
        .i_pin    (I_TIMER_IN),
        .i_rising (sc1_r[SC1_RISING_BIT]),
        .o_level  (),
        .o_edge   (edge_evt)
    );

    // Prescaler feeding the counter from the CPU clock.
    presc_div #(.DIV_W(DIV_W)) u_presc (
        .i_clk    (I_CLK),
        .i_resetn (I_RESETN),
        .i_run    (run),
        .i_triple (sc1_r[SC1_TRIPLE_BIT]),
        .i_sel    (psel_r),
        .o_tick   (tick)
    );

    // Configuration registers; all but the three-bit prescaler select are eight bits, and all are writable at any time.
    always_comb begin
        mode_nxt    = mode_r;
        psel_nxt    = psel_r;
        sc1_nxt     = sc1_r;
        reload_nxt  = reload_r;
        compare_nxt = compare_r;
        if (wr) begin
            case (idx)
                IDX_MODE:    mode_nxt    = wdat;
                IDX_STAT1:   psel_nxt    = wdat[SC0_PS_LSB +: PSEL_W];
                IDX_STAT2:   sc1_nxt     = wdat;
                IDX_RELOAD:  reload_nxt  = wdat;
                IDX_COMPARE: compare_nxt = wdat;
                default:     mode_nxt    = mode_r;
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            mode_r    <= MODE_RST;
            psel_r    <= PSEL_RST;
            sc1_r     <= REG_RST;
            reload_r  <= REG_RST;
            compare_r <= REG_RST;
        end else begin
            mode_r    <= mode_nxt;
            psel_r    <= psel_nxt;
            sc1_r     <= sc1_nxt;
            reload_r  <= reload_nxt;
            compare_r <= compare_nxt;
        end
    end

    // Counter: software load first, then edge reload, then the increment.
    always_comb begin
        count_nxt = count_r;
        changed   = 1'b0;
        if (ld_wr) begin
            count_nxt = wdat;
            changed   = 1'b1;
        end else if (reload_evt) begin
            count_nxt = reload_r;
            changed   = 1'b1;
        end else if (tick) begin
            count_nxt = count_r + 8'h01;
            changed   = 1'b1;
        end
    end

    // Output level: low at the compare match, high again at the top count.
    always_comb begin
        out_nxt = out_r;
        if (changed && (count_nxt == compare_r)) begin
            out_nxt = 1'b0;
        end else if (changed && (count_nxt == COUNT_TOP)) begin
            out_nxt = 1'b1;
        end
    end

    // Sticky flags; a set in the cycle of a write-zero clear wins.
    always_comb begin
        flags_set = {tick && !reload_evt && !ld_wr && (count_r == COUNT_TOP),
                     changed && (count_nxt == compare_r),
                     edge_evt};
        flags_nxt = flags_r;
        if (wr && (idx == IDX_STAT1)) begin
            flags_nxt = flags_r & wdat[SC0_FLAG_LSB +: 3];
        end
        flags_nxt = flags_nxt | flags_set;
    end

    // Wake request pulses on every active pin edge, running or not.
    always_comb begin
        wake_nxt = edge_evt;
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            count_r <= COUNT_ZERO;
            out_r   <= OUT_RST;
            flags_r <= FLAGS_RST;
            wake_r  <= 1'b0;
        end else begin
            count_r <= count_nxt;
            out_r   <= out_nxt;
            flags_r <= flags_nxt;
            wake_r  <= wake_nxt;
        end
    end

    // Read mux; unmapped addresses read as zero but are still acknowledged.
    always_comb begin
        case (idx)
            IDX_MODE:    rd8 = mode_r;
            IDX_STAT1:   rd8 = {flags_r, 2'b00, psel_r};
            IDX_STAT2:   rd8 = sc1_r;
            IDX_COUNT:   rd8 = count_r;
            IDX_RELOAD:  rd8 = reload_r;
            IDX_COMPARE: rd8 = compare_r;
            IDX_LOAD:    rd8 = count_r;
            default:     rd8 = 8'h00;
        endcase
        rdat_nxt = rdat_r;
        if (hit && !req.we) begin
            rdat_nxt = {24'h000000, rd8};
        end
        ack_nxt = hit;
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ack_r  <= 1'b0;
            rdat_r <= '0;
        end else begin
            ack_r  <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    // Compare and the reload PWM share this single pin pair; no capture function drives it.
    assign O_TIMER_OUT    = out_r;
    assign O_TIMER_OUT_OE = mode_r[MC_OUT_EN_BIT];
    assign O_PULLUP_EN    = sc1_r[SC1_PULLUP_BIT];
    assign O_WAKE         = wake_r;
    assign O_WB_ACK       = ack_r;
    assign O_WB_DAT       = rdat_r;

    // Checking helpers: expected ratio and cycles since the last strobe.
    logic [8:0] ratio_chk;
    logic [8:0] gap_r;
    logic       gap_ok_r;
    logic       cfg_wr;
    assign ratio_chk = (sc1_r[SC1_TRIPLE_BIT] ? RATIO_THREE : RATIO_ONE) << psel_r;
    assign cfg_wr    = wr && ((idx == IDX_STAT1) || (idx == IDX_STAT2) || (idx == IDX_MODE));

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            gap_r    <= 9'h000;
            gap_ok_r <= 1'b0;
        end else if (!run || cfg_wr) begin
            gap_r    <= 9'h000;
            gap_ok_r <= 1'b0;
        end else if (tick) begin
            gap_r    <= 9'h000;
            gap_ok_r <= 1'b1;
        end else begin
            gap_r    <= gap_r + 9'h001;
        end
    end

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RESETN);

    sequence s_pin_rise;
        sc1_r[SC1_RISING_BIT] && !cfg_wr && $rose(I_TIMER_IN) ##1 I_TIMER_IN && !cfg_wr;
    endsequence

    sequence s_reload_with_tick;
        reload_evt && tick && !ld_wr;
    endsequence

    chk_reload_wins_tick: assert property (
        s_reload_with_tick |=> count_r == $past(reload_r))
        else $error("reload did not win over increment");

    chk_edge_reload_value: assert property (
        s_pin_rise ##0 run && edge_mode && !ld_wr ##1 !ld_wr |=> count_r == $past(reload_r))
        else $error("active edge did not reload the counter");

    chk_tick_increments: assert property (
        tick && !reload_evt && !ld_wr |=> count_r == $past(count_r) + 8'h01)
        else $error("counter did not step on the prescaled strobe");

    chk_compare_low: assert property (
        changed && count_nxt == compare_r |=> !O_TIMER_OUT)
        else $error("output not low at compare match");

    chk_top_high: assert property (
        tick && !reload_evt && !ld_wr && count_r == 8'hfe && compare_r != 8'hff |=> O_TIMER_OUT && count_r == 8'hff)
        else $error("output not high at top count");

    chk_wrap_zero: assert property (
        tick && !reload_evt && !ld_wr && count_r == 8'hff |=> count_r == 8'h00 && flags_r[2])
        else $error("counter did not wrap to zero with overflow flag");

    chk_prescale_ratio: assert property (
        tick && gap_ok_r |-> gap_r + 9'h001 == ratio_chk)
        else $error("prescaled strobe spacing wrong");

    chk_pin_wake: assert property (
        s_pin_rise |=> edge_evt ##1 O_WAKE)
        else $error("rising pin edge did not raise wake");

    chk_mode_start: assert property (
        wr && idx == IDX_MODE && wdat == MODE_START |=> run && edge_mode && O_TIMER_OUT_OE)
        else $error("start value did not enable edge mode and output");

    chk_compare_write: assert property (
        wr && idx == IDX_COMPARE |=> compare_r == $past(wdat) ##1 compare_r == $past(compare_r))
        else $error("compare write not stored");

    chk_bus_ack: assert property (
        hit |=> O_WB_ACK ##1 !O_WB_ACK)
        else $error("bus ack not one cycle after request");

    // The counter must not move between strobes, and a stopped timer must not strobe at all.
    chk_count_holds: assert property (
        !tick && !reload_evt && !ld_wr |=> count_r == $past(count_r))
        else $error("counter moved without a strobe");

    chk_stop_no_tick: assert property (
        !run |-> !tick)
        else $error("prescaled strobe while stopped");

    // A software load lands in the counter whatever else happens in that cycle.
    chk_load_value: assert property (
        ld_wr |=> count_r == $past(wdat))
        else $error("software load not taken by the counter");

    // Once low, the output stays low until the counter becomes the top count.
    chk_low_holds: assert property (
        !O_TIMER_OUT && !(changed && count_nxt == COUNT_TOP) |=> !O_TIMER_OUT)
        else $error("output rose before the top count");

    // Every active edge raises the wake request one cycle later.
    chk_edge_wake: assert property (
        edge_evt |=> O_WAKE)
        else $error("active edge did not raise wake");

    // A read of the counter returns the value it held when the request was taken.
    chk_count_read: assert property (
        hit && !req.we && idx == IDX_COUNT |=> O_WB_DAT == {24'h000000, $past(count_r)})
        else $error("counter read returned wrong data");
endmodule

// *** pin_source.sv ***
// Model of the external signal source that drives the timer input pin.
`timescale 1ns/10ps
module pin_source (
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_on,
    input  wire logic [15:0] i_period,
    input  wire logic [15:0] i_high,
    output logic             o_pin
);
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic        pin_nxt;

    // The bench picks a period inside the lock window, so the output stays locked.
    always_comb begin
        cnt_nxt = (cnt_r >= i_period - 16'd1) ? 16'd0 : cnt_r + 16'd1;
        pin_nxt = i_on && (cnt_r < i_high);
        if (!i_on) begin
            cnt_nxt = 16'd0;
        end
    end

    // The pin is held low while the source is switched off.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_r <= 16'd0;
            o_pin <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            o_pin <= pin_nxt;
        end
    end
endmodule

// *** tb.sv ***
// Self-checking testbench for the edge-locked reload timer.
`timescale 1ns/10ps
module tb;
    import edge_timer_pkg::*;
    logic              clk = 1'b0;
    logic              resetn = 1'b0;
    logic              cyc = 1'b0;
    logic              stb = 1'b0;
    logic              we = 1'b0;
    logic [ADR_W-1:0]  adr = '0;
    logic [3:0]        sel = 4'h0;
    logic [WB_W-1:0]   wdat = '0;
    logic [WB_W-1:0]   rdat;
    logic              ack;
    logic              pin;
    logic              tout;
    logic              toe;
    logic              pull;
    logic              wake;
    logic              src_on = 1'b0;
    int                failures = 0;
    int                checks_done = 0;
    int                d1, d2, d3, lo, hi, n;

    // Clock at 20 MHz.
    always #25 clk = ~clk;

    edge_locked_reload_timer uut (
        .I_CLK(clk), .I_RESETN(resetn), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
        .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
        .I_TIMER_IN(pin), .O_TIMER_OUT(tout), .O_TIMER_OUT_OE(toe), .O_PULLUP_EN(pull), .O_WAKE(wake)
    );

    pin_source src (
        .i_clk(clk), .i_resetn(resetn), .i_on(src_on), .i_period(16'd178), .i_high(16'd89), .o_pin(pin)
    );

    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t %s: got %0d expected %0d", $time, what, got, exp);
        end
    endtask

    // One classic Wishbone cycle, held until ack is sampled high.
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] r);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= 4'h1;
        wdat <= {24'h0, d};
        @(posedge clk);
        while (ack !== 1'b1) begin
            @(posedge clk);
        end
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, idx, d, r);
    endtask

    task automatic rdreg(input logic [7:0] idx, input logic [7:0] exp, input string what);
        logic [31:0] r;
        bus(1'b0, idx, 8'h00, r);
        check(r, {24'h0, exp}, what);
    endtask

    // Counts falling clock edges until the chosen signal shows the wanted level.
    task automatic wait_sig(input logic v, input int which, output int cnt);
        logic s;
        cnt = 0;
        s = (which == 0) ? tout : (which == 1) ? pin : wake;
        while (s !== v && cnt < 3000) begin
            @(negedge clk);
            cnt++;
            s = (which == 0) ? tout : (which == 1) ? pin : wake;
        end
        if (cnt >= 3000) begin
            failures++;
            $display("BAD t=%0t wait for level timed out", $time);
            final_report;
        end
    endtask

    // Cycles from the active pin edge to the output falling edge.
    task automatic edge_delay(input logic pv, output int d);
        int k;
        wait_sig(~pv, 1, k);
        wait_sig(pv, 1, k);
        wait_sig(1'b0, 0, d);
    endtask

    task automatic final_report;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence: registers, prescaler ratios, locked operation, polarity and wake.
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        check(tout, 1, "output idle level");
        check(toe, 0, "output enable at reset");
        for (int i = 8'hd5; i <= 8'hda; i++) begin
            rdreg(i[7:0], 8'h00, "reset value");
        end
        wr(8'h10, 8'hff);
        rdreg(8'h10, 8'h00, "unmapped read");
        wr(IDX_RELOAD, 8'ha5);
        rdreg(IDX_RELOAD, 8'ha5, "reload readback");
        wr(IDX_COMPARE, 8'h5a);
        rdreg(IDX_COMPARE, 8'h5a, "compare readback");
        wr(IDX_STAT1, 8'hff);
        rdreg(IDX_STAT1, 8'h07, "first status readback");
        wr(IDX_STAT2, 8'h02);
        check(pull, 1, "pull-up enable");
        wr(IDX_COMPARE, 8'hfd);
        for (int s = 0; s < 16; s++) begin
            wr(IDX_MODE, 8'h00);
            wr(IDX_STAT1, {5'h0, s[2:0]});
            wr(IDX_STAT2, {7'h0, s[3]});
            wr(IDX_LOAD, 8'hff);
            wr(IDX_LOAD, 8'hfc);
            wr(IDX_MODE, MODE_START);
            wait_sig(1'b0, 0, n);
            wait_sig(1'b1, 0, lo);
            check(lo, (2 << s[2:0]) * (s[3] ? 3 : 1), "low time per ratio");
        end
        check(toe, 1, "output enabled by start value");
        wr(IDX_MODE, 8'h00);
        wr(IDX_STAT1, 8'h00);
        wr(IDX_STAT2, 8'h04);
        wr(IDX_RELOAD, 8'd160);
        wr(IDX_COMPARE, 8'd210);
        wr(IDX_MODE, MODE_START);
        src_on <= 1'b1;
        edge_delay(1'b1, d1);
        edge_delay(1'b1, d1);
        wait_sig(1'b1, 0, lo);
        wait_sig(1'b0, 0, hi);
        check(d1 >= 50 && d1 <= 56, 1, "edge to fall delay");
        check(lo, 45, "locked low time");
        check(lo + hi, 178, "output period follows input");
        wr(IDX_RELOAD, 8'd170);
        wr(IDX_COMPARE, 8'd230);
        edge_delay(1'b1, d2);
        edge_delay(1'b1, d2);
        wait_sig(1'b1, 0, lo);
        check(d2 - d1, 10, "delay tracks new reload and compare");
        check(lo, 25, "low time tracks new compare");
        wr(IDX_STAT2, 8'h00);
        edge_delay(1'b0, d3);
        edge_delay(1'b0, d3);
        check(d3, d2, "falling edge active");
        wr(IDX_MODE, 8'h00);
        check(toe, 0, "output disabled when mode cleared");
        wait_sig(1'b1, 1, n);
        wait_sig(1'b0, 1, n);
        wait_sig(1'b1, 2, n);
        check(n < 8, 1, "wake pulse while stopped");
        final_report;
    end

    // Watchdog that ends a hung run.
    initial begin
        #1500000;
        failures++;
        $display("BAD t=%0t watchdog expired", $time);
        final_report;
    end
endmodule
